// File: logic/mqh_pkg.sv
package mqh_pkg;
    localparam int         NUM_AXES      = 4;
    localparam int         HALL_BASE     = 4;      // First general input used for Hall signals
    localparam int         HALL_PER_AXIS = 3;
    // Register map, byte addresses on the plain port
    localparam logic [3:0] ADDR_QUAL     = 4'h0;
    localparam logic [3:0] ADDR_CFG      = 4'h4;
    localparam logic [3:0] ADDR_HOME     = 4'h8;
    localparam logic [3:0] ADDR_STAT     = 4'hC;
    // Field positions
    localparam int         HOME_START_LSB = 0;
    localparam int         HOME_ABORT_LSB = 4;
    localparam int         CFG_HALL_SRC   = 0;
    // Reset values: pass-through on every axis, Hall from general inputs
    localparam logic [7:0] QUAL_RST      = 8'hFF;
    localparam logic       HALL_SRC_RST  = 1'b0;
    // Direction pin level that means travel toward the home switch
    localparam logic       DIR_TOWARD    = 1'b1;

    // Two-bit select: first bit high, second bit low
    typedef enum logic [1:0] {
        MQH_QUAL_SINCOS = 2'b00,
        MQH_QUAL_ICOS   = 2'b01,
        MQH_QUAL_COS    = 2'b10,
        MQH_QUAL_PASS   = 2'b11
    } mqh_qual_e;

    typedef enum logic [1:0] {
        MQH_ST_IDLE = 2'b00,
        MQH_ST_SEEK = 2'b01,
        MQH_ST_REV  = 2'b10,
        MQH_ST_DONE = 2'b11
    } mqh_state_e;

    typedef struct packed {
        logic ref_pulse;
        logic enc_sine;
        logic enc_cosine;
        logic home_switch;
    } mqh_axis_in_s;

    typedef struct packed {
        logic hall_a;
        logic hall_b;
        logic hall_c;
    } mqh_hall_s;
endpackage

// File: logic/mqh_axis.sv
`timescale 1ns/1ns
module mqh_axis (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire mqh_pkg::mqh_axis_in_s i_pins,
    input  wire logic [1:0]            i_qual_sel,
    input  wire logic                  i_start,
    input  wire logic                  i_abort,
    output logic                       o_move,
    output logic                       o_dir,
    output logic                       o_busy,
    output logic                       o_done,
    output logic                       o_qmark,
    output logic                       o_home
);
    mqh_pkg::mqh_axis_in_s meta_q;
    mqh_pkg::mqh_axis_in_s sync_q;
    mqh_pkg::mqh_state_e   state_q, state_d;
    logic                  qual;

    // Two-stage synchroniser; first stage read only by the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_pins;
            sync_q <= meta_q;
        end
    end

    // Marker gating by the per-axis select
    always_comb begin
        unique case (mqh_pkg::mqh_qual_e'(i_qual_sel))
            mqh_pkg::MQH_QUAL_PASS:   qual = sync_q.ref_pulse;
            mqh_pkg::MQH_QUAL_COS:    qual = sync_q.ref_pulse & sync_q.enc_cosine;
            mqh_pkg::MQH_QUAL_ICOS:   qual = sync_q.ref_pulse & ~sync_q.enc_cosine;
            mqh_pkg::MQH_QUAL_SINCOS: qual = sync_q.ref_pulse & sync_q.enc_cosine & sync_q.enc_sine;
        endcase
    end

    // Home search: toward switch, reverse, stop on a high qualified marker
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            mqh_pkg::MQH_ST_IDLE: if (i_start) state_d = mqh_pkg::MQH_ST_SEEK;
            mqh_pkg::MQH_ST_SEEK: if (sync_q.home_switch) state_d = mqh_pkg::MQH_ST_REV;
            mqh_pkg::MQH_ST_REV:  if (qual) state_d = mqh_pkg::MQH_ST_DONE;
            mqh_pkg::MQH_ST_DONE: state_d = mqh_pkg::MQH_ST_IDLE;
        endcase
        // Abort has priority so a runaway search can always be stopped
        if (i_abort) state_d = mqh_pkg::MQH_ST_IDLE;
    end

    // Move, direction, busy and done registered from the next state so they change with it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= mqh_pkg::MQH_ST_IDLE;
            o_move  <= 1'b0;
            o_dir   <= mqh_pkg::DIR_TOWARD;
            o_busy  <= 1'b0;
            o_done  <= 1'b0;
            o_qmark <= 1'b0;
            o_home  <= 1'b0;
        end else begin
            state_q <= state_d;
            o_move  <= (state_d == mqh_pkg::MQH_ST_SEEK) || (state_d == mqh_pkg::MQH_ST_REV);
            o_dir   <= (state_d == mqh_pkg::MQH_ST_REV) ? ~mqh_pkg::DIR_TOWARD : mqh_pkg::DIR_TOWARD;
            o_busy  <= state_d != mqh_pkg::MQH_ST_IDLE;
            o_done  <= state_d == mqh_pkg::MQH_ST_DONE;
            o_qmark <= qual;
            o_home  <= sync_q.home_switch;
        end
    end

    property p_qual_pass;
        @(posedge i_clk) disable iff (i_rst)
        (i_qual_sel == 2'h3) |=> (o_qmark == $past(sync_q.ref_pulse));
    endproperty
    a_qual_pass: assert property (p_qual_pass) else $error("pass-through marker mismatch");

    property p_qual_cos;
        @(posedge i_clk) disable iff (i_rst)
        (i_qual_sel == 2'h2 && !sync_q.enc_cosine) |=> !o_qmark;
    endproperty
    a_qual_cos: assert property (p_qual_cos) else $error("cosine gating let marker through");

    property p_qual_icos;
        @(posedge i_clk) disable iff (i_rst)
        (i_qual_sel == 2'h1 && sync_q.enc_cosine) |=> !o_qmark;
    endproperty
    a_qual_icos: assert property (p_qual_icos) else $error("inverse cosine gating let marker through");

    property p_qual_sincos;
        @(posedge i_clk) disable iff (i_rst)
        (i_qual_sel == 2'h0 && sync_q.ref_pulse && sync_q.enc_sine && sync_q.enc_cosine) |=> o_qmark;
    endproperty
    a_qual_sincos: assert property (p_qual_sincos) else $error("sine and cosine gating lost marker");

    property p_sync_delay;
        @(posedge i_clk) disable iff (i_rst)
        $past(!i_rst, 2) |-> (sync_q.home_switch == $past(i_pins.home_switch, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("home input not two-stage synchronised");

    property p_reverse_at_home;
        @(posedge i_clk) disable iff (i_rst)
        (state_q == mqh_pkg::MQH_ST_SEEK && sync_q.home_switch && !i_abort)
            |=> (o_move && o_dir != mqh_pkg::DIR_TOWARD);
    endproperty
    a_reverse_at_home: assert property (p_reverse_at_home) else $error("no reversal at home switch");

    property p_stop_at_marker;
        @(posedge i_clk) disable iff (i_rst)
        (state_q == mqh_pkg::MQH_ST_REV && qual && !i_abort) |=> (!o_move ##1 (!o_done && !o_busy));
    endproperty
    a_stop_at_marker: assert property (p_stop_at_marker) else $error("axis did not stop on marker");
endmodule // mqh_axis

// File: logic/mqh_top.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
module mqh_top (
    input  wire logic                                      i_clk,
    input  wire logic                                      i_rst,
    input  wire mqh_pkg::mqh_axis_in_s [mqh_pkg::NUM_AXES-1:0] i_axis_pins,
    input  wire logic [15:0]                               i_gen_input,
    input  wire logic [11:0]                               i_main_hall,
    input  wire logic [3:0]                                i_addr,
    input  wire logic [31:0]                               i_wdata,
    input  wire logic                                      i_wr,
    input  wire logic                                      i_rd,
    output logic      [31:0]                               o_rdata,
    output logic      [mqh_pkg::NUM_AXES-1:0]              o_move,
    output logic      [mqh_pkg::NUM_AXES-1:0]              o_dir,
    output mqh_pkg::mqh_hall_s [mqh_pkg::NUM_AXES-1:0]     o_hall,
    output logic      [3:0]                                o_gen_low
);
    localparam int N = mqh_pkg::NUM_AXES;

    logic [7:0]   qual_q, qual_d;
    logic         hall_src_q, hall_src_d;
    logic [N-1:0] start_q, start_d;
    logic [N-1:0] abort_q, abort_d;
    logic [N-1:0] done_flag_q, done_flag_d;
    logic [31:0]  rdata_d;
    logic [N-1:0] busy, done, qmark, home;
    logic [15:0]  gen_meta_q, gen_sync_q;
    logic [11:0]  main_meta_q, main_sync_q;
    mqh_pkg::mqh_hall_s [N-1:0] hall_d;
    logic [3:0]   gen_low_d;

    // Register writes, command pulses and sticky done flags
    always_comb begin
        qual_d      = qual_q;
        hall_src_d  = hall_src_q;
        start_d     = '0;
        abort_d     = '0;
        done_flag_d = done_flag_q;
        if (i_wr && i_addr == mqh_pkg::ADDR_QUAL) qual_d = i_wdata[7:0];
        if (i_wr && i_addr == mqh_pkg::ADDR_CFG) hall_src_d = i_wdata[mqh_pkg::CFG_HALL_SRC];
        if (i_wr && i_addr == mqh_pkg::ADDR_HOME) begin
            start_d = i_wdata[mqh_pkg::HOME_START_LSB +: N] & ~busy;
            abort_d = i_wdata[mqh_pkg::HOME_ABORT_LSB +: N];
        end
        // A fresh start clears done; a completing search sets it and wins
        done_flag_d = (done_flag_d & ~start_d) | done;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_rd) begin
            unique case (i_addr)
                mqh_pkg::ADDR_QUAL: rdata_d[7:0] = qual_q;
                mqh_pkg::ADDR_CFG:  rdata_d[mqh_pkg::CFG_HALL_SRC] = hall_src_q;
                mqh_pkg::ADDR_HOME: rdata_d[N-1:0] = busy;
                mqh_pkg::ADDR_STAT: rdata_d[4*N-1:0] = {home, qmark, busy, done_flag_q};
                default:            rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            qual_q      <= mqh_pkg::QUAL_RST;
            hall_src_q  <= mqh_pkg::HALL_SRC_RST;
            start_q     <= '0;
            abort_q     <= '0;
            done_flag_q <= '0;
            o_rdata     <= 32'h0000_0000;
        end else begin
            qual_q      <= qual_d;
            hall_src_q  <= hall_src_d;
            start_q     <= start_d;
            abort_q     <= abort_d;
            done_flag_q <= done_flag_d;
            o_rdata     <= rdata_d;
        end
    end

    // Hall and general input synchronisers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gen_meta_q  <= 16'h0000;
            gen_sync_q  <= 16'h0000;
            main_meta_q <= 12'h000;
            main_sync_q <= 12'h000;
        end else begin
            gen_meta_q  <= i_gen_input;
            gen_sync_q  <= gen_meta_q;
            main_meta_q <= i_main_hall;
            main_sync_q <= main_meta_q;
        end
    end

    // Per-axis Hall mapping, ordered B, A, C from the lowest input upward
    always_comb begin
        gen_low_d = gen_sync_q[3:0];
        for (int k = 0; k < N; k++) begin
            if (hall_src_q) begin
                hall_d[k].hall_b = main_sync_q[3*k];
                hall_d[k].hall_a = main_sync_q[3*k+1];
                hall_d[k].hall_c = main_sync_q[3*k+2];
            end else begin
                hall_d[k].hall_b = gen_sync_q[mqh_pkg::HALL_BASE+3*k];
                hall_d[k].hall_a = gen_sync_q[mqh_pkg::HALL_BASE+3*k+1];
                hall_d[k].hall_c = gen_sync_q[mqh_pkg::HALL_BASE+3*k+2];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_hall    <= '0;
            o_gen_low <= 4'h0;
        end else begin
            o_hall    <= hall_d;
            o_gen_low <= gen_low_d;
        end
    end

    // One independent qualifier and home search per axis
    for (genvar g = 0; g < N; g++) begin : g_axis
        mqh_axis u_axis (
            .i_clk      (i_clk),
            .i_rst      (i_rst),
            .i_pins     (i_axis_pins[g]),
            .i_qual_sel (qual_q[2*g +: 2]),
            .i_start    (start_q[g]),
            .i_abort    (abort_q[g]),
            .o_move     (o_move[g]),
            .o_dir      (o_dir[g]),
            .o_busy     (busy[g]),
            .o_done     (done[g]),
            .o_qmark    (qmark[g]),
            .o_home     (home[g])
        );
    end

    property p_hall_general;
        @(posedge i_clk) disable iff (i_rst)
        !hall_src_q |=> (o_hall[N-1].hall_c == $past(gen_sync_q[15]) && o_hall[0].hall_b == $past(gen_sync_q[4]));
    endproperty
    a_hall_general: assert property (p_hall_general) else $error("general input Hall map wrong");

    property p_hall_main;
        @(posedge i_clk) disable iff (i_rst)
        hall_src_q |=> (o_hall[0].hall_a == $past(main_sync_q[1]));
    endproperty
    a_hall_main: assert property (p_hall_main) else $error("main connector Hall source not used");

    property p_start_runs;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == mqh_pkg::ADDR_HOME && i_wdata[0] && !i_wdata[4] && !busy[0])
            |=> ##1 (o_move[0] && o_dir[0] == mqh_pkg::DIR_TOWARD);
    endproperty
    a_start_runs: assert property (p_start_runs) else $error("home search did not start toward home");

    property p_read_qual;
        @(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr == mqh_pkg::ADDR_QUAL) |=> (o_rdata[7:0] == $past(qual_q));
    endproperty
    a_read_qual: assert property (p_read_qual) else $error("select readback mismatch");

    // Read data must not linger, or a later poll could take a stale word
    property p_rdata_idle;
        @(posedge i_clk) disable iff (i_rst)
        !i_rd |=> (o_rdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood outside its cycle");

    property p_qual_write;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == mqh_pkg::ADDR_QUAL) |=> (qual_q == $past(i_wdata[7:0]));
    endproperty
    a_qual_write: assert property (p_qual_write) else $error("select write not taken");

    property p_hall_src_write;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == mqh_pkg::ADDR_CFG) |=> (hall_src_q == $past(i_wdata[0]));
    endproperty
    a_hall_src_write: assert property (p_hall_src_write) else $error("Hall source write not taken");

    property p_hall_main_top;
        @(posedge i_clk) disable iff (i_rst)
        hall_src_q |=> (o_hall[N-1].hall_c == $past(main_sync_q[11]) && o_hall[N-1].hall_b == $past(main_sync_q[9]));
    endproperty
    a_hall_main_top: assert property (p_hall_main_top) else $error("main connector Hall order wrong");

    // General inputs 0 to 3 pass through untouched by the Hall mapping
    property p_gen_low;
        @(posedge i_clk) disable iff (i_rst)
        o_gen_low == $past(gen_sync_q[3:0]);
    endproperty
    a_gen_low: assert property (p_gen_low) else $error("low general inputs disturbed");

    property p_abort_stops;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == mqh_pkg::ADDR_HOME && i_wdata[5]) |=> ##1 !o_move[1];
    endproperty
    a_abort_stops: assert property (p_abort_stops) else $error("abort did not stop the axis");

    // A second start on a busy axis is refused; the axis itself takes start only in MQH_ST_IDLE
    property p_start_refused;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == mqh_pkg::ADDR_HOME && i_wdata[0] && busy[0]) |=> !start_q[0];
    endproperty
    a_start_refused: assert property (p_start_refused) else $error("start accepted on busy axis");

    property p_done_set;
        @(posedge i_clk) disable iff (i_rst)
        done[0] |=> done_flag_q[0];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set at marker stop");

    property p_done_sticky;
        @(posedge i_clk) disable iff (i_rst)
        (done_flag_q[0] && !start_q[0]) |=> done_flag_q[0];
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost without a new start");
endmodule // mqh_top

// File: testbench/mqh_far_side.sv
`timescale 1ns/1ns
// Encoders, home switches and a moving stage for four axes
module mqh_far_side #(
    parameter int HOME_AT = 40,
    parameter int MARK_AT = 16,
    parameter int STEP    = 8
) (
    input  wire logic                        i_clk,
    input  wire logic [3:0]                  i_move,
    input  wire logic [3:0]                  i_dir,
    input  wire logic                        i_force,
    input  wire mqh_pkg::mqh_axis_in_s [3:0] i_forced,
    output mqh_pkg::mqh_axis_in_s [3:0]      o_pins,
    output int                               o_pos [4]
);
    int pos_q [4] = '{100, 100, 100, 100};
    int div_q = 0;

    // Slow stage: one step every STEP cycles, so sync lag never overshoots a marker
    always @(posedge i_clk) begin
        div_q <= (div_q == STEP - 1) ? 0 : div_q + 1;
        for (int k = 0; k < 4; k++) begin
            if (i_move[k] && div_q == 0) begin
                pos_q[k] <= (i_dir[k] == mqh_pkg::DIR_TOWARD) ? pos_q[k] - 1 : pos_q[k] + 1;
            end
        end
    end

    // Marker once per 32 steps; switch closed below HOME_AT; forced pins win
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_pins[k].ref_pulse   = (pos_q[k] % 32) == MARK_AT;
            o_pins[k].enc_sine    = (pos_q[k] % 4) < 2;
            o_pins[k].enc_cosine  = ((pos_q[k] + 1) % 4) < 2;
            o_pins[k].home_switch = pos_q[k] < HOME_AT;
            if (i_force) o_pins[k] = i_forced[k];
            o_pos[k] = pos_q[k];
        end
    end
endmodule // mqh_far_side

// File: testbench/mqh_top_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module mqh_top_bench;
    logic                        i_clk = 1'b0;
    logic                        i_rst = 1'b1;
    mqh_pkg::mqh_axis_in_s [3:0] pins;
    mqh_pkg::mqh_axis_in_s [3:0] forced = '0;
    mqh_pkg::mqh_hall_s [3:0]    hall;
    logic [15:0]                 gen = 16'h0000;
    logic [11:0]                 mhall = 12'h000;
    logic [3:0]                  addr = 4'h0;
    logic [31:0]                 wdata = 32'h0, rdata, got, ev, seed = 32'h4D;
    logic                        wr = 1'b0, rd = 1'b0, rd_chk = 1'b0, rd_seen = 1'b0;
    logic                        force_en = 1'b0, hall_chk = 1'b0;
    logic [3:0]                  move, dir, gen_low;
    logic [15:0]                 hv;
    int                          pos [4];
    int                          n_errors = 0, compares = 0;
    logic [31:0]                 rd_q [$];
    logic [15:0]                 hall_q [$];
    localparam int               MARK_POS = 48;  // First marker above the switch edge

    mqh_top mqh_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_axis_pins(pins), .i_gen_input(gen),
        .i_main_hall(mhall), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_move(move), .o_dir(dir), .o_hall(hall), .o_gen_low(gen_low));
    mqh_far_side mqh_far_side_inst (.i_clk(i_clk), .i_move(move), .i_dir(dir), .i_force(force_en),
        .i_forced(forced), .o_pins(pins), .o_pos(pos));

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected qualified marker for one axis
    function automatic logic qual(logic [1:0] s, mqh_pkg::mqh_axis_in_s p);
        case (s)
            mqh_pkg::MQH_QUAL_PASS: return p.ref_pulse;
            mqh_pkg::MQH_QUAL_COS:  return p.ref_pulse & p.enc_cosine;
            mqh_pkg::MQH_QUAL_ICOS: return p.ref_pulse & ~p.enc_cosine;
            default:                return p.ref_pulse & p.enc_sine & p.enc_cosine;
        endcase
    endfunction

    // One bus cycle; a checked read leaves its expected word in the queue
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic chk);
        @(posedge i_clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        rd_chk <= chk & ~w;
        if (chk && !w) rd_q.push_back(d);
        @(posedge i_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        rd_chk <= 1'b0;
        #1 got = rdata;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wrap_up();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Result watcher: read data stand only in the cycle after the strobe
    always @(posedge i_clk) begin
        rd_seen <= rd & rd_chk;
        if (rd_seen) begin
            ev = rd_q.pop_front();
            `CHK(rdata, ev)
        end
        if (hall_chk) begin
            hv = hall_q.pop_front();
            `CHK({gen_low, hall}, hv)
        end
    end

    // Hang guard, well beyond the several hundred cycles the run needs
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end

    initial begin
        logic [7:0]  q;
        logic [3:0]  mk, hm;
        logic [11:0] h;
        tick(12);
        i_rst <= 1'b0;
        // Reset values and an unmapped hole
        bus(1'b0, mqh_pkg::ADDR_QUAL, 32'h0000_00FF, 1'b1);
        bus(1'b0, mqh_pkg::ADDR_CFG, 32'h0, 1'b1);
        bus(1'b0, mqh_pkg::ADDR_STAT, 32'h0, 1'b1);
        bus(1'b0, 4'h2, 32'h0, 1'b1);
        // Every select on every axis, each axis with a different one
        for (int r = 0; r < 8; r++) begin
            for (int k = 0; k < 4; k++) q[2*k +: 2] = 2'(r + k);
            @(posedge i_clk);
            forced <= 16'(rnd());
            force_en <= 1'b1;
            bus(1'b1, mqh_pkg::ADDR_QUAL, {24'h0, q}, 1'b0);
            tick(4);
            for (int k = 0; k < 4; k++) begin
                mk[k] = qual(q[2*k +: 2], forced[k]);
                hm[k] = forced[k].home_switch;
            end
            bus(1'b0, mqh_pkg::ADDR_STAT, {16'h0, hm, mk, 8'h00}, 1'b1);
            bus(1'b0, mqh_pkg::ADDR_QUAL, {24'h0, q}, 1'b1);
        end
        // Hall mapping from both sources
        for (int m = 0; m < 6; m++) begin
            @(posedge i_clk);
            gen <= 16'(rnd());
            mhall <= 12'(rnd());
            bus(1'b1, mqh_pkg::ADDR_CFG, {31'h0, m[0]}, 1'b0);
            tick(4);
            for (int k = 0; k < 4; k++) begin
                h[3*k +: 3] = m[0] ? {mhall[3*k+1], mhall[3*k], mhall[3*k+2]}
                                   : {gen[5+3*k], gen[4+3*k], gen[6+3*k]};
            end
            hall_q.push_back({gen[3:0], h});
            @(posedge i_clk);
            hall_chk <= 1'b1;
            @(posedge i_clk);
            hall_chk <= 1'b0;
            bus(1'b0, mqh_pkg::ADDR_CFG, {31'h0, m[0]}, 1'b1);
        end
        // Release the pins, start one axis and abort it mid-move
        @(posedge i_clk);
        force_en <= 1'b0;
        bus(1'b1, mqh_pkg::ADDR_HOME, 32'h2, 1'b0);
        tick(3);
        bus(1'b1, mqh_pkg::ADDR_HOME, 32'h20, 1'b0);
        bus(1'b0, mqh_pkg::ADDR_HOME, 32'h0, 1'b1);
        bus(1'b0, mqh_pkg::ADDR_STAT, 32'h0, 1'b1);
        // Full search on all axes; markers passed on the way in are ignored
        bus(1'b1, mqh_pkg::ADDR_QUAL, 32'hFF, 1'b0);
        bus(1'b1, mqh_pkg::ADDR_HOME, 32'hF, 1'b0);
        bus(1'b1, mqh_pkg::ADDR_HOME, 32'hF, 1'b0);
        for (int t = 0; t < 1000; t++) begin
            bus(1'b0, mqh_pkg::ADDR_HOME, 32'h0, 1'b0);
            if (got[3:0] === 4'h0) break;
        end
        bus(1'b0, mqh_pkg::ADDR_STAT, 32'h0000_0F0F, 1'b1);
        for (int k = 0; k < 4; k++) `CHK(pos[k], MARK_POS)
        tick(3);
        wrap_up();
    end
endmodule // mqh_top_bench
